// >>> logic/t2fb_top.sv
// holds the timer2 flag, external trigger edge and serial baud source selection logic
// assumes overflow pulses and serial mode come from logic on core_clk; the trigger pin is asynchronous
//
// Function
// - a timer2 overflow sets the overflow flag unless a baud select bit is 1; only software clears it.
// - if enabled, a falling trigger pin edge requests capture or reload and sets a flag only software clears.
// - with the receive select bit 0, the receiver takes timer1 overflow as baud tick in serial modes 1 and 3.
// - with the transmit select bit 1, the transmitter takes timer2 overflow as baud tick in modes 1 and 3.
`timescale 1ns/1ps
`default_nettype none

module t2fb_top (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // register bus
    input  wire t2fb_pkg::t2fb_apb_req_t apb_req,
    output var  t2fb_pkg::t2fb_apb_rsp_t apb_rsp,
    // timer overflow pulses and serial mode
    input  wire logic                  t1_overflow,
    input  wire logic                  t2_overflow,
    input  wire logic [1:0]            serial_mode,
    // external trigger pin and capture request
    input  wire logic                  ext_trigger_pin,
    output logic                       ext_capture_req,
    // serial baud ticks
    output logic                       rx_baud_tick,
    output logic                       tx_baud_tick,
    // interrupt
    output logic                       irq
);

    // ==========================================================
    // timing and hazards at a glance
    // bus side:
    //   setup seen at edge n loads pready, prdata and pslverr for the access phase
    //   the access phase commits at edge n+1, so every transfer has zero wait states
    //   back to back transfers are fine, a setup may follow an access directly
    //   read data is taken at the setup edge; a flag that sets during the access
    //   cycle is reported by the next read, never lost
    //   status writes are dropped without an error; only unmapped offsets get pslverr
    //   clear reads back as zero, it holds no state of its own
    //   no byte strobes: every write replaces the whole register
    // trigger pin side:
    //   two synchroniser stages, then one history stage for the edge detector
    //   so a falling pin level becomes a request at the third edge after it
    //   all three stages reset to the idle high level to avoid a false edge at release
    //   a pin held low through reset still reports one edge shortly after release
    //   the request and the edge flag both need the enable bit at detection time,
    //   an enable written later does not revive an edge already seen
    //   pulses shorter than one clock period may be missed by the synchroniser
    // overflow side:
    //   overflow pulses come from logic on core_clk and are read without synchronising
    //   while either baud select is set timer2 runs as a rate generator, so its
    //   rollovers are no events and leave the overflow flag alone
    //   baud ticks lag the chosen overflow by one edge, the cost of flopped outputs
    //   modes 0 and 2 keep both ticks low whatever the selects say
    // flag side:
    //   a set and a clear of one flag at the same edge leave it set, so no event
    //   can be lost to a clear that races with it
    //   irq is built from the next flags and enables, so it moves with the flag
    //   at the same edge instead of one cycle behind
    //   masking an enable drops irq but leaves the status bit for polling

    // ==========================================================
    // state
    t2fb_pkg::t2fb_state_t st_reg;
    t2fb_pkg::t2fb_state_t st_next;

    // true when the address hits a mapped register
    function automatic logic t2fb_mapped(input logic [t2fb_pkg::ADDR_W-1:0] a);
        t2fb_mapped = (a == t2fb_pkg::OFF_CTRL) || (a == t2fb_pkg::OFF_STATUS) ||
                      (a == t2fb_pkg::OFF_CLEAR) || (a == t2fb_pkg::OFF_IRQ_EN);
    endfunction : t2fb_mapped

    // serial modes that draw their rate from a timer overflow
    function automatic logic t2fb_timer_mode(input logic [1:0] m);
        t2fb_timer_mode = (m == t2fb_pkg::SMODE_1) || (m == t2fb_pkg::SMODE_3);
    endfunction : t2fb_timer_mode

    // ==========================================================
    // next state
    always_comb begin
        logic                          setup;
        logic                          commit;
        logic                          rx_sel;
        logic                          tx_sel;
        logic                          ext_en;
        logic                          fall;
        logic [t2fb_pkg::FLG_W-1:0]    set_v;
        logic [t2fb_pkg::FLG_W-1:0]    clr_v;
        logic [t2fb_pkg::DATA_W-1:0]   rdata;
        setup  = 1'b0;
        commit = 1'b0;
        rx_sel = 1'b0;
        tx_sel = 1'b0;
        ext_en = 1'b0;
        fall   = 1'b0;
        set_v  = '0;
        clr_v  = '0;
        rdata  = '0;
        st_next = st_reg;

        // bus phases: answer prepared in setup, committed in the ready access cycle
        setup  = apb_req.psel && !apb_req.penable;
        commit = apb_req.psel && apb_req.penable && st_reg.rsp.pready;

        // register writes
        if (commit && apb_req.pwrite) begin
            unique case (apb_req.paddr)
                t2fb_pkg::OFF_CTRL: begin
                    st_next.ctrl = apb_req.pwdata[t2fb_pkg::CTRL_W-1:0];
                end
                t2fb_pkg::OFF_CLEAR: begin
                    clr_v = apb_req.pwdata[t2fb_pkg::FLG_W-1:0];
                end
                t2fb_pkg::OFF_IRQ_EN: begin
                    st_next.ien = apb_req.pwdata[t2fb_pkg::FLG_W-1:0];
                end
                default: begin
                    // status is read only, unmapped is refused by pslverr
                end
            endcase
        end

        // selects act from the stored control bits
        rx_sel = st_reg.ctrl[t2fb_pkg::CTRL_RX_SEL];
        tx_sel = st_reg.ctrl[t2fb_pkg::CTRL_TX_SEL];
        ext_en = st_reg.ctrl[t2fb_pkg::CTRL_EXT_EN];

        // trigger pin synchroniser; only the second stage feeds the edge detector
        st_next.trig_s1   = ext_trigger_pin;
        st_next.trig_s2   = st_reg.trig_s1;
        st_next.trig_prev = st_reg.trig_s2;
        fall = st_reg.trig_prev && !st_reg.trig_s2;

        // capture or reload request from a falling trigger edge
        st_next.capture_req = fall && ext_en;

        // flag events; in baud mode the overflow is a rate, not an event
        set_v[t2fb_pkg::FLG_OVF] = t2_overflow && !rx_sel && !tx_sel;
        set_v[t2fb_pkg::FLG_EXT] = fall && ext_en;

        // sticky flags: a set in the clearing cycle wins
        st_next.flags = (st_reg.flags & ~clr_v) | set_v;

        // level interrupt from enabled flags
        st_next.irq = |(st_next.flags & st_next.ien);

        // baud tick selection, silent outside modes 1 and 3
        st_next.rx_tick = t2fb_timer_mode(serial_mode) &&
                          (rx_sel ? t2_overflow : t1_overflow);
        st_next.tx_tick = t2fb_timer_mode(serial_mode) &&
                          (tx_sel ? t2_overflow : t1_overflow);

        // read mux; clear register reads as zero
        unique case (apb_req.paddr)
            t2fb_pkg::OFF_CTRL: begin
                rdata[t2fb_pkg::CTRL_W-1:0] = st_reg.ctrl;
            end
            t2fb_pkg::OFF_STATUS: begin
                rdata[t2fb_pkg::FLG_W-1:0] = st_reg.flags;
            end
            t2fb_pkg::OFF_IRQ_EN: begin
                rdata[t2fb_pkg::FLG_W-1:0] = st_reg.ien;
            end
            default: begin
                rdata = '0;
            end
        endcase

        // response: one wait-free access phase after every setup
        if (setup) begin
            st_next.rsp.pready  = 1'b1;
            st_next.rsp.prdata  = apb_req.pwrite ? '0 : rdata;
            st_next.rsp.pslverr = !t2fb_mapped(apb_req.paddr);
        end else if (commit || !apb_req.psel) begin
            st_next.rsp.pready  = 1'b0;
            st_next.rsp.prdata  = '0;
            st_next.rsp.pslverr = 1'b0;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // bus answer idle, no transfer in flight
            st_reg.rsp.prdata   <= '0;
            st_reg.rsp.pready   <= 1'b0;
            st_reg.rsp.pslverr  <= 1'b0;
            // software visible registers
            st_reg.ctrl         <= t2fb_pkg::CTRL_RST;
            st_reg.flags        <= t2fb_pkg::FLG_RST;
            st_reg.ien          <= t2fb_pkg::IEN_RST;
            st_reg.irq          <= 1'b0;
            // synchroniser at the pin's idle level
            st_reg.trig_s1      <= 1'b1;   // idle high so reset release is no edge
            st_reg.trig_s2      <= 1'b1;
            st_reg.trig_prev    <= 1'b1;
            // no pulse pending on any output
            st_reg.capture_req  <= 1'b0;
            st_reg.rx_tick      <= 1'b0;
            st_reg.tx_tick      <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign apb_rsp         = st_reg.rsp;
    assign ext_capture_req = st_reg.capture_req;
    assign rx_baud_tick    = st_reg.rx_tick;
    assign tx_baud_tick    = st_reg.tx_tick;
    assign irq             = st_reg.irq;

endmodule : t2fb_top

`default_nettype wire

// >>> common/t2fb_pkg.sv
// holds constants and carrier types for the timer2 flag and baud select block
// assumes an apb3 master on the core clock and a 32-bit data bus
package t2fb_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CLEAR  = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 12'h00c;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_RX_SEL  = 0;
    localparam int unsigned CTRL_TX_SEL  = 1;
    localparam int unsigned CTRL_EXT_EN  = 2;
    localparam int unsigned CTRL_W       = 3;
    localparam int unsigned FLG_OVF      = 0;
    localparam int unsigned FLG_EXT      = 1;
    localparam int unsigned FLG_W        = 2;

    // ==========================================================
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h0;
    localparam logic [FLG_W-1:0]  FLG_RST   = 2'h0;
    localparam logic [FLG_W-1:0]  IEN_RST   = 2'h0;

    // ==========================================================
    // serial port modes that take the baud tick from a timer
    localparam logic [1:0] SMODE_1 = 2'h1;
    localparam logic [1:0] SMODE_3 = 2'h3;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } t2fb_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } t2fb_apb_rsp_t;

    typedef struct packed {
        t2fb_apb_rsp_t     rsp;
        logic [CTRL_W-1:0] ctrl;
        logic [FLG_W-1:0]  flags;
        logic [FLG_W-1:0]  ien;
        logic              irq;
        logic              trig_s1;
        logic              trig_s2;
        logic              trig_prev;
        logic              capture_req;
        logic              rx_tick;
        logic              tx_tick;
    } t2fb_state_t;

endpackage : t2fb_pkg

// >>> tb/t2fb_checker.sv
// concurrent checks on the ports of t2fb_top
// assumes one core clock domain; ctrl and enable are shadowed from committed apb writes
`timescale 1ns/1ps
`default_nettype none
module t2fb_checker (
    // clock, reset and bus
    input wire logic                    core_clk,
    input wire logic                    arst_n,
    input wire t2fb_pkg::t2fb_apb_req_t apb_req,
    input wire t2fb_pkg::t2fb_apb_rsp_t apb_rsp,
    // timer, pin and serial side
    input wire logic                    t1_overflow,
    input wire logic                    t2_overflow,
    input wire logic [1:0]              serial_mode,
    input wire logic                    ext_trigger_pin,
    input wire logic                    ext_capture_req,
    input wire logic                    rx_baud_tick,
    input wire logic                    tx_baud_tick,
    input wire logic                    irq
);
    // ==========================================================
    // shadow registers, updated only at a commit edge
    logic [2:0] ctl_reg;
    logic [1:0] ien_reg;
    logic       wr_ok;
    logic       mode_ok;
    logic       rx_src;
    logic       tx_src;
    assign wr_ok   = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
    assign mode_ok = serial_mode[0]; // modes 1 and 3 share bit 0
    // overflow that each baud path should follow one edge later
    assign rx_src  = mode_ok && (ctl_reg[0] ? t2_overflow : t1_overflow);
    assign tx_src  = mode_ok && (ctl_reg[1] ? t2_overflow : t1_overflow);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_reg <= 3'h0;
            ien_reg <= 2'h0;
        end else if (wr_ok && apb_req.paddr == t2fb_pkg::OFF_CTRL) begin
            ctl_reg <= apb_req.pwdata[2:0];
        end else if (wr_ok && apb_req.paddr == t2fb_pkg::OFF_IRQ_EN) begin
            ien_reg <= apb_req.pwdata[1:0];
        end
    end
    // ==========================================================
    // assertions; the overflow irq check excludes any write at the same edge
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_rx_tick_src: assert property (rx_baud_tick == $past(rx_src))
        else $error("rx tick does not follow selected overflow");
    a_tx_tick_src: assert property (tx_baud_tick == $past(tx_src))
        else $error("tx tick does not follow selected overflow");
    a_ovf_flag_irq: assert property (t2_overflow && ctl_reg[1:0] == 2'h0 && ien_reg[0] && !wr_ok |=> irq)
        else $error("overflow did not raise irq");
    a_ext_edge_req: assert property ($fell(ext_trigger_pin) && ctl_reg[2] |-> ##[2:5] ext_capture_req)
        else $error("falling trigger gave no capture request");
    a_capture_one_cycle: assert property (ext_capture_req |=> !ext_capture_req)
        else $error("capture request longer than one cycle");
    c_rx_from_t2: cover property (rx_baud_tick && ctl_reg[0]);
    c_capture: cover property (ext_capture_req);
    c_irq_rise: cover property ($rose(irq));
endmodule : t2fb_checker
bind t2fb_top t2fb_checker u_chk (
    .core_clk        (core_clk),
    .arst_n          (arst_n),
    .apb_req         (apb_req),
    .apb_rsp         (apb_rsp),
    .t1_overflow     (t1_overflow),
    .t2_overflow     (t2_overflow),
    .serial_mode     (serial_mode),
    .ext_trigger_pin (ext_trigger_pin),
    .ext_capture_req (ext_capture_req),
    .rx_baud_tick    (rx_baud_tick),
    .tx_baud_tick    (tx_baud_tick),
    .irq             (irq)
);
`default_nettype wire

// >>> tb/t2fb_partner.sv
// far-side model: two free running timers and the trigger pin
// assumes the bench pulses fall_req for one cycle to ask for a low pulse
`timescale 1ns/1ps
`default_nettype none
module t2fb_partner (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // bench request
    input  wire logic fall_req,
    // overflows and pin
    output logic      t1_overflow,
    output logic      t2_overflow,
    output logic      ext_trigger_pin
);
    // ==========================================================
    // periods 3 and 5 so the two overflow sources can be told apart
    logic [2:0] t1_reg;
    logic [2:0] t2_reg;
    logic [2:0] low_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            t1_reg  <= 3'h0;
            t2_reg  <= 3'h0;
            low_reg <= 3'h0;
        end else begin
            t1_reg  <= (t1_reg == 3'h2) ? 3'h0 : t1_reg + 3'h1;
            t2_reg  <= (t2_reg == 3'h4) ? 3'h0 : t2_reg + 3'h1;
            low_reg <= fall_req ? 3'h6 : ((low_reg != 3'h0) ? low_reg - 3'h1 : 3'h0);
        end
    end
    // pulses one cycle wide; pin pulled up when idle
    assign t1_overflow     = (t1_reg == 3'h2);
    assign t2_overflow     = (t2_reg == 3'h4);
    assign ext_trigger_pin = (low_reg == 3'h0);
endmodule : t2fb_partner
`default_nettype wire

// >>> tb/t2fb_top_test.sv
// self-checking bench for t2fb_top
// assumes the checker binds itself and t2fb_partner models timers and pin
`timescale 1ns/1ps
`default_nettype none
module t2fb_top_test;
    // ==========================================================
    // signals
    logic                    core_clk    = 1'b0;
    logic                    arst_n      = 1'b0;
    logic                    fall_req    = 1'b0;
    logic [1:0]              serial_mode = 2'h0;
    t2fb_pkg::t2fb_apb_req_t apb_req     = '0;
    t2fb_pkg::t2fb_apb_rsp_t apb_rsp;
    logic                    t1_overflow, t2_overflow, ext_trigger_pin;
    logic                    ext_capture_req, rx_baud_tick, tx_baud_tick, irq;
    logic [32:0]             exp_q[$];
    logic [2:0]              c;
    logic                    tm;
    int                      nrx, ntx, ncap;
    int                      fails       = 0;
    int                      check_count = 0;
    int                      seed        = 32'hd441;
    always #2.5 core_clk = ~core_clk;
    t2fb_top dut (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .apb_req         (apb_req),
        .apb_rsp         (apb_rsp),
        .t1_overflow     (t1_overflow),
        .t2_overflow     (t2_overflow),
        .serial_mode     (serial_mode),
        .ext_trigger_pin (ext_trigger_pin),
        .ext_capture_req (ext_capture_req),
        .rx_baud_tick    (rx_baud_tick),
        .tx_baud_tick    (tx_baud_tick),
        .irq             (irq)
    );
    t2fb_partner u_far (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .fall_req        (fall_req),
        .t1_overflow     (t1_overflow),
        .t2_overflow     (t2_overflow),
        .ext_trigger_pin (ext_trigger_pin)
    );
    // ==========================================================
    // tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // one transfer; an idle cycle precedes the setup so no signal is driven twice per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        if (apb_rsp.pready !== 1'b1) begin
            fails++;
            print_verdict();
        end
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // read results are judged against the oldest note when they complete
    always @(posedge core_clk) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready && !apb_req.pwrite)
            check({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        // status first, before the partner's first timer2 overflow can set a flag
        rd(t2fb_pkg::OFF_STATUS, 33'h0);
        rd(t2fb_pkg::OFF_CTRL, 33'h0);
        rd(12'h010, 33'h1_0000_0000);
        apb(1'b1, t2fb_pkg::OFF_IRQ_EN, 32'h3);
        apb(1'b1, t2fb_pkg::OFF_STATUS, 32'h3);
        rd(t2fb_pkg::OFF_IRQ_EN, 33'h3);
        // every select and enable combination; the mode walk puts both rx select values into modes 1 and 3, tx select 0 into mode 1 and 1 into mode 3
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            serial_mode <= {c[1], c[0] ^ c[2]};
            apb(1'b1, t2fb_pkg::OFF_CTRL, {29'($random(seed)), c});
            apb(1'b1, t2fb_pkg::OFF_CLEAR, 32'h3);
            rd(t2fb_pkg::OFF_CTRL, {30'h0, c});
            fall_req <= 1'b1;
            @(posedge core_clk);
            fall_req <= 1'b0;
            nrx  = 0;
            ntx  = 0;
            ncap = 0;
            // 15 cycles hold exactly 5 timer1 and 3 timer2 overflows of the partner
            repeat (15) begin
                @(posedge core_clk);
                nrx  += int'(rx_baud_tick);
                ntx  += int'(tx_baud_tick);
                ncap += int'(ext_capture_req);
            end
            tm = (serial_mode == t2fb_pkg::SMODE_1) || (serial_mode == t2fb_pkg::SMODE_3);
            check(33'(nrx), 33'(tm ? (c[0] ? 3 : 5) : 0));
            check(33'(ntx), 33'(tm ? (c[1] ? 3 : 5) : 0));
            check(33'(ncap), {32'h0, c[2]});
            rd(t2fb_pkg::OFF_STATUS, {31'h0, c[2], c[1:0] == 2'h0});
            check({32'h0, irq}, {32'h0, c[2] || c[1:0] == 2'h0});
        end
        // mask with a flag still set, then clear it
        apb(1'b1, t2fb_pkg::OFF_IRQ_EN, 32'h0);
        @(posedge core_clk);
        check({32'h0, irq}, 33'h0);
        apb(1'b1, t2fb_pkg::OFF_CLEAR, 32'h3);
        rd(t2fb_pkg::OFF_STATUS, 33'h0);
        print_verdict();
    end
endmodule : t2fb_top_test
`default_nettype wire
